/* File: verilog/gdio_pin.sv */
// gdio_pin: one bidirectional pad with optional input, output and enable
// registers, single or double rate on input and output, configured over APB.
// assumes the fabric supplies one clock used as both capture_clock and
// launch_clock; pad signals are synchronous to it.
//
// Local design decisions: the APB interface to the registers and the address map.
module gdio_pin
	import gdio_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	output logic [1:0] in_data_o,
	output logic bypass_input_o,
	input wire logic [1:0] out_data_i,
	input wire logic oe_i,
	input wire logic pad_in_i,
	output logic pad_out_o,
	output logic pad_oe_o
);

	////////////////////////////////////////////////////////////////////////
	// reset release
	logic rst_meta_r;
	logic rst_q_r;

	always_ff @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_meta_r <= 1'b0;
			rst_q_r <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_q_r <= rst_meta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb slave
	gdio_cfg_t cfg_r;
	gdio_cfg_t cfg_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic [GDIO_STAT_W-1:0] stat_w;
	logic acc_w;
	logic hit_w;

	assign acc_w = psel_i && penable_i;
	assign hit_w = (paddr_i == GDIO_CFG_OFS) || (paddr_i == GDIO_STAT_OFS);
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && !hit_w;
	assign prdata_o = prdata_r;

	always_comb
	begin
		cfg_nxt = cfg_r;
		prdata_nxt = prdata_r;
		if (psel_i && !penable_i && !pwrite_i)
		begin
			if (paddr_i == GDIO_CFG_OFS)
				prdata_nxt = {{(32-GDIO_CFG_W){1'b0}}, cfg_r};
			else if (paddr_i == GDIO_STAT_OFS)
				prdata_nxt = {{(32-GDIO_STAT_W){1'b0}}, stat_w};
			else
				prdata_nxt = 32'h00000000;
		end
		if (acc_w && pwrite_i && (paddr_i == GDIO_CFG_OFS))
			cfg_nxt = gdio_cfg_t'(pwdata_i[GDIO_CFG_W-1:0]);
	end

	always_ff @(posedge clk_sys_i or negedge rst_q_r)
	begin
		if (!rst_q_r)
		begin
			cfg_r <= GDIO_CFG_RST;
			prdata_r <= 32'h00000000;
		end
		else
		begin
			cfg_r <= cfg_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// effective modes
	logic ddr_in_w;
	logic ddr_out_w;
	logic out_val_w;

	// differential pads have no double-rate cells
	assign ddr_in_w = cfg_r.ddr_in && !cfg_r.lvds_gpio;
	assign ddr_out_w = cfg_r.ddr_out && !cfg_r.lvds_gpio;
	assign out_val_w = out_data_i[0] ^ cfg_r.out_invert;

	////////////////////////////////////////////////////////////////////////
	// rising-edge registers: capture and launch share clk_sys_i
	logic in_pos_r;
	logic in_pos_nxt;
	logic in_rs_r;
	logic in_rs_nxt;
	logic out_pos_r;
	logic out_pos_nxt;
	logic out_hold_r;
	logic out_hold_nxt;
	logic oe_pos_r;
	logic oe_pos_nxt;
	logic in_neg_r;

	always_comb
	begin
		in_pos_nxt = pad_in_i;
		in_rs_nxt = in_neg_r;
		out_pos_nxt = ddr_out_w ? out_data_i[0] : out_val_w;
		out_hold_nxt = out_data_i[1];
		oe_pos_nxt = oe_i;
	end

	always_ff @(posedge clk_sys_i or negedge rst_q_r)
	begin
		if (!rst_q_r)
		begin
			in_pos_r <= 1'b0;
			in_rs_r <= 1'b0;
			out_pos_r <= 1'b0;
			out_hold_r <= 1'b0;
			oe_pos_r <= 1'b0;
		end
		else
		begin
			in_pos_r <= in_pos_nxt;
			in_rs_r <= in_rs_nxt;
			out_pos_r <= out_pos_nxt;
			out_hold_r <= out_hold_nxt;
			oe_pos_r <= oe_pos_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// falling-edge registers; input and output ones shared between single and double rate
	logic in_neg_nxt;
	logic out_neg_r;
	logic out_neg_nxt;
	logic oe_neg_r;
	logic oe_neg_nxt;

	always_comb
	begin
		in_neg_nxt = pad_in_i;
		if (!ddr_out_w)
			out_neg_nxt = out_val_w;
		else if (cfg_r.ddr_resync)
			out_neg_nxt = out_hold_r;
		else
			out_neg_nxt = out_data_i[1];
		oe_neg_nxt = oe_i;
	end

	always_ff @(negedge clk_sys_i or negedge rst_q_r)
	begin
		if (!rst_q_r)
		begin
			in_neg_r <= 1'b0;
			out_neg_r <= 1'b0;
			oe_neg_r <= 1'b0;
		end
		else
		begin
			in_neg_r <= in_neg_nxt;
			out_neg_r <= out_neg_nxt;
			oe_neg_r <= oe_neg_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pad and fabric muxing
	always_comb
	begin
		if (!cfg_r.in_reg)
			in_data_o = {1'b0, pad_in_i};
		else if (ddr_in_w && cfg_r.ddr_resync)
			in_data_o = {in_rs_r, in_pos_r};
		else if (ddr_in_w)
			in_data_o = {in_neg_r, in_pos_r};
		else
			in_data_o = {1'b0, cfg_r.in_fall ? in_neg_r : in_pos_r};
		bypass_input_o = cfg_r.in_reg ? 1'b0 : pad_in_i;
		if (!cfg_r.out_reg)
			pad_out_o = out_val_w;
		else if (ddr_out_w)
			pad_out_o = clk_sys_i ? out_pos_r : out_neg_r;
		else
			pad_out_o = cfg_r.out_fall ? out_neg_r : out_pos_r;
		if (!cfg_r.oe_reg)
			pad_oe_o = oe_i;
		else
			pad_oe_o = cfg_r.oe_fall ? oe_neg_r : oe_pos_r;
	end

	assign stat_w = {bypass_input_o, pad_oe_o, pad_out_o, in_data_o, pad_in_i};

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_in_plain;
		@(posedge clk_sys_i) disable iff (!rst_q_r)
		!cfg_r.in_reg |-> in_data_o == {1'b0, pad_in_i};
	endproperty
	a_in_plain: assert property (p_in_plain) else $error("plain input not on bit 0");

	sequence s_ddr_in_steady;
		ddr_in_w && cfg_r.in_reg && !cfg_r.ddr_resync ##1 $stable(cfg_r);
	endsequence
	property p_in_rise;
		@(posedge clk_sys_i) disable iff (!rst_q_r)
		s_ddr_in_steady |-> in_data_o[0] == $past(pad_in_i);
	endproperty
	a_in_rise: assert property (p_in_rise) else $error("rising sample missing on bit 0");

	property p_resync_in;
		@(posedge clk_sys_i) disable iff (!rst_q_r)
		(ddr_in_w && cfg_r.ddr_resync && cfg_r.in_reg) ##1 $stable(cfg_r) |-> in_data_o[1] == $past(in_neg_r);
	endproperty
	a_resync_in: assert property (p_resync_in) else $error("falling sample not realigned");

	property p_out_plain;
		@(posedge clk_sys_i) disable iff (!rst_q_r)
		!cfg_r.out_reg |-> pad_out_o == (out_data_i[0] ^ cfg_r.out_invert);
	endproperty
	a_out_plain: assert property (p_out_plain) else $error("unregistered output wrong");

	property p_out_inv;
		@(posedge clk_sys_i) disable iff (!rst_q_r)
		(cfg_r.out_reg && !ddr_out_w && !cfg_r.out_fall) ##1 $stable(cfg_r)
			|-> pad_out_o == ($past(out_data_i[0]) ^ cfg_r.out_invert);
	endproperty
	a_out_inv: assert property (p_out_inv) else $error("registered output value wrong");

	property p_resync_out;
		@(posedge clk_sys_i) disable iff (!rst_q_r)
		(ddr_out_w && cfg_r.ddr_resync) ##1 1'b1 |-> out_hold_r == $past(out_data_i[1]);
	endproperty
	a_resync_out: assert property (p_resync_out) else $error("resync bit 1 not held");

	property p_bypass;
		@(posedge clk_sys_i) disable iff (!rst_q_r)
		bypass_input_o == (cfg_r.in_reg ? 1'b0 : pad_in_i);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass path wrong");

	property p_oe;
		@(posedge clk_sys_i) disable iff (!rst_q_r)
		(!cfg_r.oe_reg |-> pad_oe_o == oe_i) and ((cfg_r.oe_reg && !cfg_r.oe_fall) ##1 $stable(cfg_r)
			|-> pad_oe_o == $past(oe_i));
	endproperty
	a_oe: assert property (p_oe) else $error("output enable path wrong");

	property p_lvds;
		@(posedge clk_sys_i) disable iff (!rst_q_r)
		cfg_r.lvds_gpio |-> !ddr_in_w && !ddr_out_w;
	endproperty
	a_lvds: assert property (p_lvds) else $error("double rate on differential pad");

	// negedge checks see the level held through the phase before the edge
	property p_ddr_out_high;
		@(negedge clk_sys_i) disable iff (!rst_q_r)
		(cfg_r.out_reg && ddr_out_w) ##1 $stable(cfg_r) |-> pad_out_o == $past(out_data_i[0]);
	endproperty
	a_ddr_out_high: assert property (p_ddr_out_high) else $error("high phase not bit 0");

	property p_out_fall;
		@(negedge clk_sys_i) disable iff (!rst_q_r)
		(cfg_r.out_reg && !ddr_out_w && cfg_r.out_fall) ##1 $stable(cfg_r)
			|-> pad_out_o == ($past(out_data_i[0]) ^ cfg_r.out_invert);
	endproperty
	a_out_fall: assert property (p_out_fall) else $error("falling output register wrong");

	property p_ddr_in_fall;
		@(negedge clk_sys_i) disable iff (!rst_q_r)
		(ddr_in_w && cfg_r.in_reg && !cfg_r.ddr_resync) ##1 $stable(cfg_r) |-> in_data_o[1] == $past(pad_in_i);
	endproperty
	a_ddr_in_fall: assert property (p_ddr_in_fall) else $error("falling sample missing on bit 1");

endmodule : gdio_pin

/* File: shared/gdio_pkg.sv */
// gdio_pkg: register map, configuration layout and reset values for the
// per-pin double-rate I/O logic.
// assumes a 32-bit APB master and a single fabric clock.
package gdio_pkg;

	////////////////////////////////////////////////////////////////////////
	// register map (byte addresses)
	localparam logic [11:0] GDIO_CFG_OFS = 12'h000;
	localparam logic [11:0] GDIO_STAT_OFS = 12'h004;

	localparam int GDIO_CFG_W = 11;
	localparam int GDIO_STAT_W = 6;

	// status word bit positions
	localparam int GDIO_ST_PAD_IN = 0;
	localparam int GDIO_ST_IN0 = 1;
	localparam int GDIO_ST_IN1 = 2;
	localparam int GDIO_ST_PAD_OUT = 3;
	localparam int GDIO_ST_PAD_OE = 4;
	localparam int GDIO_ST_BYPASS = 5;

	////////////////////////////////////////////////////////////////////////
	// configuration word, msb first
	typedef struct packed {
		logic lvds_gpio;   // pin is a differential pair used single ended
		logic out_invert;  // invert output value on the unregistered and single-rate paths
		logic oe_fall;     // enable register on falling edge
		logic out_fall;    // single-rate output register on falling edge
		logic in_fall;     // single-rate input register on falling edge
		logic ddr_resync;  // double_rate_mode aligned to rising edge
		logic ddr_out;     // double_rate_mode on the output path
		logic ddr_in;      // double_rate_mode on the input path
		logic oe_reg;      // register the output enable
		logic out_reg;     // register the output data
		logic in_reg;      // register the input data
	} gdio_cfg_t;

	localparam gdio_cfg_t GDIO_CFG_RST = 11'h000;

endpackage : gdio_pkg

/* File: sim/gdio_pad_model.sv */
// gdio_pad_model: board device on the far side of the pad.
// assumes the pin's own driver wins whenever its enable is high.
module gdio_pad_model
(
	input wire logic clk_i,
	input wire logic rise_bit_i,
	input wire logic fall_bit_i,
	input wire logic pad_out_i,
	input wire logic pad_oe_i,
	output logic pad_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic drv;
	// set after the opposite edge so the pin sees a settled level
	always @(posedge clk_i or negedge clk_i) drv <= clk_i ? fall_bit_i : rise_bit_i;
	// contention not modelled: the pin driver simply overrides
	assign pad_o = pad_oe_i ? pad_out_i : drv;
endmodule : gdio_pad_model

/* File: sim/tb_top.sv */
// tb_top: apb configuration plus pad checks in both clock phases.
// assumes the pin answers apb with no wait states but never relies on it.
module tb_top
	import gdio_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys_i;
	logic rst_n_i = 1'b0;
	logic psel, pen, pwr, pready, pslverr, bypass, oe, pad, pad_out, pad_oe, rise_val, fall_val, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] in_data, out_data;
	logic [4:0] pins;
	int n_errors, samples_checked, cyc;
	logic [10:0] cfgs [13] = '{11'h000, 11'h000, 11'h007, 11'h201, 11'h009, 11'h029, 11'h016, 11'h036, 11'h416,
		11'h009, 11'h029, 11'h409, 11'h041};
	logic [1:0] outs [13] = '{2'h2, 2'h1, 2'h1, 2'h0, 2'h0, 2'h0, 2'h2, 2'h2, 2'h2, 2'h0, 2'h0, 2'h0, 2'h0};
	logic [4:0] eh [13] = '{5'h05, 5'h1D, 5'h10, 5'h19, 5'h01, 5'h01, 5'h08, 5'h08, 5'h08, 5'h02, 5'h02, 5'h00, 5'h01};
	logic [4:0] el [13] = '{5'h05, 5'h1D, 5'h10, 5'h19, 5'h01, 5'h01, 5'h1D, 5'h1D, 5'h08, 5'h02, 5'h02, 5'h00, 5'h01};
	// bit 1 of the input is driven to zero outside double rate; the 409 and 041 entries still check it
	logic [4:0] msk [13] = '{5'h1D, 5'h1D, 5'h1D, 5'h1D, 5'h1F, 5'h1F, 5'h1D, 5'h1D, 5'h1D, 5'h1F, 5'h1F, 5'h1F,
		5'h1F};
	logic [12:0] oes = 13'h01CA;
	logic [12:0] his = 13'h003B;
	logic [12:0] los = 13'h1E0B;
	assign pins = {pad_out, pad_oe, bypass, in_data};

	gdio_pin i_gdio_pin (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .in_data_o(in_data), .bypass_input_o(bypass), .out_data_i(out_data),
		.oe_i(oe), .pad_in_i(pad), .pad_out_o(pad_out), .pad_oe_o(pad_oe));
	gdio_pad_model i_gdio_pad_model (.clk_i(clk_sys_i), .rise_bit_i(rise_val), .fall_bit_i(fall_val),
		.pad_out_i(pad_out), .pad_oe_i(pad_oe), .pad_o(pad));

	////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task chk_pins(input logic [4:0] got, input logic [4:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_pins

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys_i);
		pen <= 1'b1;
		@(posedge clk_sys_i);
		while (pready !== 1'b1) @(posedge clk_sys_i);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk_sys_i);
	endtask : apb

	task results();
		$display("compares %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
		begin
			$display("No errors found");
		end
		else
		begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end

	always @(posedge clk_sys_i)
	begin
		cyc++;
		if (cyc == 1000)
		begin
			n_errors++;
			results();
		end
	end

	initial
	begin
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		out_data = 2'h0;
		oe = 1'b0;
		rise_val = 1'b0;
		fall_val = 1'b0;
		repeat (16) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		apb(1'b0, GDIO_CFG_OFS, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, err}, 32'h0);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, 32'h0);
		chk({31'h0, err}, 32'h1);
		for (int i = 0; i < 13; i++)
		begin
			// junk above the used width must read back as zero
			apb(1'b1, GDIO_CFG_OFS, {21'h1FFFFF, cfgs[i]});
			apb(1'b0, GDIO_CFG_OFS, 32'h0);
			chk(rd, {21'h0, cfgs[i]});
			oe <= oes[i];
			out_data <= outs[i];
			rise_val <= his[i];
			fall_val <= los[i];
			repeat (3) @(posedge clk_sys_i);
			#10;
			chk_pins(pins & msk[i], eh[i]);
			#25;
			chk_pins(pins & msk[i], el[i]);
			@(posedge clk_sys_i);
		end
		// output and enable registers on the falling edge: new value only after it
		apb(1'b1, GDIO_CFG_OFS, 32'h186);
		out_data <= 2'h0;
		oe <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		out_data <= 2'h1;
		oe <= 1'b1;
		#10;
		chk_pins(pins & 5'h18, 5'h00);
		#25;
		chk_pins(pins & 5'h18, 5'h18);
		@(posedge clk_sys_i);
		// status is read only; a write there must leave the configuration alone
		apb(1'b1, GDIO_STAT_OFS, 32'h0);
		apb(1'b0, GDIO_STAT_OFS, 32'h0);
		chk(rd, 32'h0000003B);
		chk({31'h0, err}, 32'h0);
		apb(1'b0, GDIO_CFG_OFS, 32'h0);
		chk(rd, 32'h00000186);
		// mid-run reset returns everything to the unregistered defaults
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		apb(1'b0, GDIO_CFG_OFS, 32'h0);
		chk(rd, 32'h0);
		#10;
		chk_pins(pins & 5'h1D, 5'h1D);
		results();
	end
endmodule : tb_top
